// ==== telegram_filter_pkg.sv ====
// Shared constants for the received-telegram filter and packet framer.
// Assumes one 20 MHz clock and a byte-wide link to the host.
package telegram_filter_pkg;

  // Clock and the transmit completion window.
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned TX_WINDOW_MS      = 40;
  localparam int unsigned TX_WINDOW_CYC     = (CLK_HZ / 1000) * TX_WINDOW_MS;
  localparam int unsigned TX_CNT_W          = 20;

  // Filter table geometry.
  localparam int unsigned FILTER_COUNT      = 4;
  localparam int unsigned MAX_DATA          = 16;
  localparam int unsigned DATA_IDX_W        = 4;
  localparam int unsigned POS_W             = 6;

  // Filter type codes.
  localparam logic [7:0]  FTYPE_SENDER_ID   = 8'h00;
  localparam logic [7:0]  FTYPE_TYPE_CODE   = 8'h01;
  localparam logic [7:0]  FTYPE_RSSI        = 8'h02;
  localparam logic [7:0]  FTYPE_DEST_ID     = 8'h03;

  // Filter action codes.
  localparam logic [7:0]  FACT_FWD_FALSE    = 8'h00;
  localparam logic [7:0]  FACT_FWD_TRUE     = 8'h80;
  localparam logic [7:0]  FACT_REP_TRUE     = 8'hC0;
  localparam logic [7:0]  FACT_REP_FALSE    = 8'h40;

  // Repeater mode that enables filter-controlled repeating.
  localparam logic [1:0]  REP_MODE_SELECTIVE = 2'h2;

  // Packet framing.
  localparam logic [7:0]  SYNC_BYTE         = 8'h55;
  localparam logic [7:0]  PTYPE_RADIO       = 8'h01;
  localparam logic [7:0]  PTYPE_RESPONSE    = 8'h02;
  localparam logic [7:0]  PTYPE_EVENT       = 8'h04;
  localparam logic [7:0]  RADIO_OPT_LEN     = 8'h07;
  localparam logic [7:0]  success_return_code     = 8'h00;
  localparam logic [7:0]  transmit_complete_event = 8'h08;
  localparam logic [7:0]  CRC_POLY          = 8'h07;
  localparam logic [7:0]  CRC_INIT          = 8'h00;
  localparam logic [7:0]  BROADCAST_BYTE    = 8'hFF;
  localparam logic [POS_W-1:0] POS_HDR_CRC  = 6'd5;
  localparam logic [POS_W-1:0] POS_DATA     = 6'd6;

  // Register map, byte addresses.
  localparam logic [7:0]  CTRL_ADDR         = 8'h00;
  localparam logic [7:0]  STATUS_ADDR       = 8'h04;
  localparam logic [7:0]  FILT_BASE_ADDR    = 8'h20;
  localparam int unsigned CTRL_REP_LSB      = 0;
  localparam int unsigned CTRL_WAIT_BIT     = 8;
  localparam int unsigned FILT_EN_BIT       = 16;
  localparam logic [1:0]  CTRL_REP_RESET    = 2'h0;

  // Sender packet kinds.
  typedef enum logic [1:0] {
    KIND_RADIO = 2'b00,
    KIND_RESP  = 2'b01,
    KIND_EVENT = 2'b11
  } pkt_kind_e;

  // Receive path states, Gray along the usual path.
  typedef enum logic [1:0] {
    RX_IDLE    = 2'b00,
    RX_COLLECT = 2'b01,
    RX_DECIDE  = 2'b11,
    RX_HOLD    = 2'b10
  } rx_state_e;

endpackage

// ==== filter_match.sv ====
// One filter entry: evaluates its condition and the resulting action.
// Assumes telegram attributes are stable while the decision is sampled.
module filter_match
  import telegram_filter_pkg::*;
(
  // Entry contents.
  input  wire logic        enable_in,
  input  wire logic [7:0]  ftype_in,
  input  wire logic [31:0] fvalue_in,
  input  wire logic [7:0]  action_in,
  // Telegram attributes.
  input  wire logic [31:0] sender_id_in,
  input  wire logic [7:0]  telegram_type_code_in,
  input  wire logic [7:0]  rssi_in,
  input  wire logic [31:0] dest_id_in,
  // Decision.
  output logic             active_out,
  output logic             forward_out,
  output logic             repeat_out
);

  logic cond;
  logic type_ok;

  // Condition per filter type; unknown types leave the entry inactive.
  always_comb begin
    type_ok = 1'b1;
    unique case (ftype_in)
      FTYPE_SENDER_ID: cond = (sender_id_in == fvalue_in);
      FTYPE_TYPE_CODE: cond = (32'(telegram_type_code_in) == fvalue_in);
      // Stronger signal has a smaller magnitude, so weaker or equal is >=.
      FTYPE_RSSI:      cond = (32'(rssi_in) >= fvalue_in);
      FTYPE_DEST_ID:   cond = (dest_id_in == fvalue_in);
      default:         {cond, type_ok} = 2'b00;
    endcase
  end

  // Action decode; repeating is only granted with forwarding.
  always_comb begin
    active_out  = enable_in & type_ok;
    forward_out = 1'b0;
    repeat_out  = 1'b0;
    unique case (action_in)
      FACT_FWD_FALSE: forward_out = ~cond;
      FACT_FWD_TRUE:  forward_out = cond;
      FACT_REP_TRUE:  {forward_out, repeat_out} = {2{cond}};
      FACT_REP_FALSE: {forward_out, repeat_out} = {2{~cond}};
      default: active_out = 1'b0;
    endcase
    if (!active_out) begin
      forward_out = 1'b0;
      repeat_out  = 1'b0;
    end
  end

endmodule

// ==== rx_telegram_filter_forwarder.sv ====
// Received-telegram filter, packet framer and host transmit handshake.
// Assumes radio bytes arrive synchronous to clk_in and the host
// takes a byte at each edge with link_ready_in high.

module rx_telegram_filter_forwarder
  import telegram_filter_pkg::*;
#(
  parameter int unsigned TX_WINDOW_CYCLES = TX_WINDOW_CYC
)(
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Register port.
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // Received telegram from the radio.
  input  wire logic        rx_start_in,
  input  wire logic [31:0] rx_sender_id_in,
  input  wire logic [31:0] rx_dest_id_in,
  input  wire logic [7:0]  rx_rssi_in,
  input  wire logic [7:0]  rx_subtel_in,
  input  wire logic [7:0]  rx_security_in,
  input  wire logic        rx_byte_valid_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_byte_is_check_in,
  input  wire logic        rx_end_in,
  output logic             rx_ready_out,
  // Host transmit requests and radio transmitter.
  input  wire logic        host_tx_req_in,
  output logic             host_tx_ready_out,
  output logic             radio_tx_start_out,
  output logic             radio_repeat_out,
  input  wire logic        radio_tx_done_in,
  // Byte link to the host.
  output logic [7:0]       link_data_out,
  output logic             link_valid_out,
  input  wire logic        link_ready_in
);

  // One CRC-8 step over a whole byte.
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Control and filter table.
  logic [1:0]  repeater_mode_select_reg;
  logic        wait_maturity_reg;
  logic        filt_en_reg     [FILTER_COUNT];
  logic [7:0]  filt_type_reg   [FILTER_COUNT];
  logic [7:0]  filt_action_reg [FILTER_COUNT];
  logic [31:0] filt_value_reg  [FILTER_COUNT];
  logic [31:0] reg_rdata_reg;
  logic [7:0]  fwd_count_reg;

  // Received telegram.
  rx_state_e   rx_state_reg;
  logic [7:0]  data_reg [MAX_DATA];
  logic [7:0]  dlen_reg;
  logic [31:0] sender_reg;
  logic [31:0] dest_reg;
  logic [7:0]  rssi_reg;
  logic [7:0]  subtel_count_reg;
  logic [7:0]  security_reg;
  logic        overflow_reg;

  // Sender and transmit tracking.
  logic        rx_pend_reg;
  logic        resp_pend_reg;
  logic        event_pend_reg;
  logic        snd_busy_reg;
  pkt_kind_e   snd_kind_reg;
  logic [POS_W-1:0] pos_reg;
  logic [7:0]  crc_reg;
  logic [7:0]  out_byte_reg;
  logic [7:0]  dlen_send_reg;
  logic        radio_busy_reg;
  logic [TX_CNT_W-1:0] tx_cnt_reg;
  logic        radio_tx_start_reg;
  logic        radio_repeat_reg;

  // Filter decisions.
  logic [FILTER_COUNT-1:0] f_active;
  logic [FILTER_COUNT-1:0] f_forward;
  logic [FILTER_COUNT-1:0] f_repeat;
  logic        decide_fwd;
  logic        decide_rep;

  logic        wr_filt;
  logic [1:0]  filt_idx;
  logic        accept;
  logic        start_send;
  pkt_kind_e   start_kind;
  logic [POS_W-1:0] last_pos;
  logic [7:0]  opt_len;
  logic [7:0]  crc_acc;
  logic [POS_W-1:0] pos_next;
  logic [7:0]  byte_next;
  logic        tx_done_evt;
  logic        snd_done;

  assign wr_filt  = (reg_addr_in[7:5] == FILT_BASE_ADDR[7:5]);
  assign filt_idx = reg_addr_in[4:3];

  // Control register writes.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      repeater_mode_select_reg <= CTRL_REP_RESET;
      wait_maturity_reg        <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == CTRL_ADDR) begin
      repeater_mode_select_reg <= reg_wdata_in[CTRL_REP_LSB +: 2];
      wait_maturity_reg        <= reg_wdata_in[CTRL_WAIT_BIT];
    end
  end

  // Filter table writes; an entry is two words, control then value.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < FILTER_COUNT; i++) begin
        filt_en_reg[i]     <= 1'b0;
        filt_type_reg[i]   <= 8'h00;
        filt_action_reg[i] <= 8'h00;
        filt_value_reg[i]  <= 32'h00000000;
      end
    end else if (reg_wr_in && wr_filt) begin
      if (!reg_addr_in[2]) begin
        filt_en_reg[filt_idx]     <= reg_wdata_in[FILT_EN_BIT];
        filt_action_reg[filt_idx] <= reg_wdata_in[15:8];
        filt_type_reg[filt_idx]   <= reg_wdata_in[7:0];
      end else begin
        filt_value_reg[filt_idx]  <= reg_wdata_in;
      end
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_reg <= 32'h00000000;
    end else if (!reg_rd_in) begin
      reg_rdata_reg <= 32'h00000000;
    end else if (reg_addr_in == CTRL_ADDR) begin
      reg_rdata_reg <= {23'h000000, wait_maturity_reg, 6'h00, repeater_mode_select_reg};
    end else if (reg_addr_in == STATUS_ADDR) begin
      reg_rdata_reg <= {16'h0000, fwd_count_reg, 4'h0, overflow_reg, radio_busy_reg,
                        snd_busy_reg, (rx_state_reg != RX_IDLE)};
    end else if (wr_filt && !reg_addr_in[2]) begin
      reg_rdata_reg <= {15'h0000, filt_en_reg[filt_idx], filt_action_reg[filt_idx],
                        filt_type_reg[filt_idx]};
    end else if (wr_filt) begin
      reg_rdata_reg <= filt_value_reg[filt_idx];
    end else begin
      reg_rdata_reg <= 32'h00000000;
    end
  end
  assign reg_rdata_out = reg_rdata_reg;

  // One evaluator per table entry.
  for (genvar g = 0; g < FILTER_COUNT; g++) begin : g_filt
    filter_match u_match (
      .enable_in             (filt_en_reg[g]),
      .ftype_in              (filt_type_reg[g]),
      .fvalue_in             (filt_value_reg[g]),
      .action_in             (filt_action_reg[g]),
      .sender_id_in          (sender_reg),
      .telegram_type_code_in (data_reg[0]),
      .rssi_in               (rssi_reg),
      .dest_id_in            (dest_reg),
      .active_out            (f_active[g]),
      .forward_out           (f_forward[g]),
      .repeat_out            (f_repeat[g])
    );
  end

  // Entries combine by OR; an empty table passes everything and repeats nothing.
  assign decide_fwd = (f_active == '0) ? 1'b1 : (|f_forward);
  assign decide_rep = decide_fwd & (|f_repeat)
                    & (repeater_mode_select_reg == REP_MODE_SELECTIVE);

  // Receive sequencing; the single buffer is held until its packet leaves.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_state_reg <= RX_IDLE;
    end else begin
      unique case (rx_state_reg)
        RX_IDLE:    if (rx_start_in) rx_state_reg <= RX_COLLECT;
        RX_COLLECT: if (rx_end_in) rx_state_reg <= RX_DECIDE;
        RX_DECIDE:  rx_state_reg <= decide_fwd ? RX_HOLD : RX_IDLE;
        RX_HOLD:    if (snd_done && snd_kind_reg == KIND_RADIO) rx_state_reg <= RX_IDLE;
      endcase
    end
  end
  assign rx_ready_out = (rx_state_reg == RX_IDLE);

  // Telegram capture; check bytes are dropped and excess bytes flag overflow.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < MAX_DATA; i++) data_reg[i] <= 8'h00;
      dlen_reg         <= 8'h00;
      sender_reg       <= 32'h00000000;
      dest_reg         <= 32'h00000000;
      rssi_reg         <= 8'h00;
      subtel_count_reg <= 8'h00;
      security_reg     <= 8'h00;
      overflow_reg     <= 1'b0;
    end else if (rx_state_reg == RX_IDLE && rx_start_in) begin
      dlen_reg         <= 8'h00;
      sender_reg       <= rx_sender_id_in;
      dest_reg         <= rx_dest_id_in;
      rssi_reg         <= rx_rssi_in;
      subtel_count_reg <= wait_maturity_reg ? rx_subtel_in : 8'h00;
      security_reg     <= rx_security_in;
      overflow_reg     <= 1'b0;
    end else if (rx_state_reg == RX_COLLECT && rx_byte_valid_in && !rx_byte_is_check_in) begin
      if (dlen_reg < 8'(MAX_DATA)) begin
        data_reg[dlen_reg[DATA_IDX_W-1:0]] <= rx_byte_in;
        dlen_reg <= dlen_reg + 8'h01;
      end else begin
        overflow_reg <= 1'b1;
      end
    end
  end

  // Pending packet flags; a new request in the cycle it is taken stays pending.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_pend_reg    <= 1'b0;
      resp_pend_reg  <= 1'b0;
      event_pend_reg <= 1'b0;
    end else begin
      rx_pend_reg    <= (rx_state_reg == RX_DECIDE && decide_fwd) |
                        (rx_pend_reg & ~(start_send && start_kind == KIND_RADIO));
      resp_pend_reg  <= (host_tx_req_in & host_tx_ready_out) |
                        (resp_pend_reg & ~(start_send && start_kind == KIND_RESP));
      event_pend_reg <= tx_done_evt |
                        (event_pend_reg & ~(start_send && start_kind == KIND_EVENT));
    end
  end

  // Radio transmitter; the completion event falls back to the window bound.
  assign tx_done_evt = radio_busy_reg &
                       (radio_tx_done_in | (tx_cnt_reg == TX_CNT_W'(TX_WINDOW_CYCLES - 1)));
  assign host_tx_ready_out = ~radio_busy_reg & ~resp_pend_reg;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      radio_busy_reg     <= 1'b0;
      tx_cnt_reg         <= '0;
      radio_tx_start_reg <= 1'b0;
    end else begin
      radio_tx_start_reg <= host_tx_req_in & host_tx_ready_out;
      if (host_tx_req_in && host_tx_ready_out) begin
        radio_busy_reg <= 1'b1;
        tx_cnt_reg     <= '0;
      end else if (tx_done_evt) begin
        radio_busy_reg <= 1'b0;
      end else if (radio_busy_reg) begin
        tx_cnt_reg <= tx_cnt_reg + 1'b1;
      end
    end
  end
  assign radio_tx_start_out = radio_tx_start_reg;

  // Repeat pulse and forwarded-telegram counter.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      radio_repeat_reg <= 1'b0;
      fwd_count_reg    <= 8'h00;
    end else begin
      radio_repeat_reg <= (rx_state_reg == RX_DECIDE) & decide_rep;
      if (rx_state_reg == RX_DECIDE && decide_fwd) fwd_count_reg <= fwd_count_reg + 8'h01;
    end
  end
  assign radio_repeat_out = radio_repeat_reg;

  // Sender arbitration: responses first so the reply is immediate.
  always_comb begin
    start_send = ~snd_busy_reg & (resp_pend_reg | event_pend_reg | rx_pend_reg);
    if (resp_pend_reg)       start_kind = KIND_RESP;
    else if (event_pend_reg) start_kind = KIND_EVENT;
    else                     start_kind = KIND_RADIO;
  end

  assign accept   = snd_busy_reg & link_ready_in;
  assign opt_len  = (snd_kind_reg == KIND_RADIO) ? RADIO_OPT_LEN : 8'h00;
  assign last_pos = POS_DATA + POS_W'(dlen_send_reg) + POS_W'(opt_len);
  assign snd_done = accept && (pos_reg == last_pos);
  assign pos_next = pos_reg + 1'b1;
  // Header checksum covers bytes 1..4; data checksum restarts after it.
  assign crc_acc  = (pos_reg == '0 || pos_reg == POS_HDR_CRC) ? CRC_INIT
                  : crc8_step(crc_reg, out_byte_reg);

  // Byte that follows the one being accepted.
  always_comb begin
    logic [POS_W-1:0] d;
    logic [POS_W-1:0] o;
    d = pos_next - POS_DATA;
    o = d - POS_W'(dlen_send_reg);
    byte_next = crc_acc;
    if (pos_next == 6'd1) begin
      byte_next = 8'h00;
    end else if (pos_next == 6'd2) begin
      byte_next = dlen_send_reg;
    end else if (pos_next == 6'd3) begin
      byte_next = opt_len;
    end else if (pos_next == 6'd4) begin
      unique case (snd_kind_reg)
        KIND_RADIO: byte_next = PTYPE_RADIO;
        KIND_RESP:  byte_next = PTYPE_RESPONSE;
        KIND_EVENT: byte_next = PTYPE_EVENT;
        default:    byte_next = 8'h00;
      endcase
    end else if (pos_next == POS_HDR_CRC) begin
      byte_next = crc_acc;
    end else if (d < POS_W'(dlen_send_reg)) begin
      if (snd_kind_reg == KIND_RADIO)      byte_next = data_reg[d[DATA_IDX_W-1:0]];
      else if (snd_kind_reg == KIND_RESP)  byte_next = success_return_code;
      else                                 byte_next = transmit_complete_event;
    end else if (o < POS_W'(opt_len)) begin
      unique case (o)
        6'd0:    byte_next = subtel_count_reg;
        6'd1:    byte_next = dest_reg[31:24];
        6'd2:    byte_next = dest_reg[23:16];
        6'd3:    byte_next = dest_reg[15:8];
        6'd4:    byte_next = dest_reg[7:0];
        6'd5:    byte_next = rssi_reg;
        default: byte_next = security_reg;
      endcase
    end
  end

  // Data length is latched at packet start; short packets carry one byte.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      snd_busy_reg  <= 1'b0;
      snd_kind_reg  <= KIND_RADIO;
      pos_reg       <= '0;
      crc_reg       <= CRC_INIT;
      out_byte_reg  <= 8'h00;
      dlen_send_reg <= 8'h00;
    end else if (start_send) begin
      snd_busy_reg <= 1'b1;
      snd_kind_reg <= start_kind;
      pos_reg      <= '0;
      crc_reg      <= CRC_INIT;
      out_byte_reg <= SYNC_BYTE;
      dlen_send_reg <= (start_kind == KIND_RADIO) ? dlen_reg : 8'h01;
    end else if (snd_done) begin
      snd_busy_reg <= 1'b0;
    end else if (accept) begin
      pos_reg      <= pos_next;
      crc_reg      <= crc_acc;
      out_byte_reg <= byte_next;
    end
  end

  assign link_valid_out = snd_busy_reg;
  assign link_data_out  = out_byte_reg;

endmodule

// ==== filter_monitor.sv ====
// Port checker for the telegram filter forwarder, bound below.
// Assumes one clock domain and an asynchronous active-low reset.
module filter_monitor #(
  parameter int unsigned TX_WINDOW_CYCLES = 50
)(
  // Clock, reset and register writes.
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  // Receive, transmit and byte link.
  input wire logic        rx_start_in,
  input wire logic        rx_end_in,
  input wire logic        rx_ready_out,
  input wire logic        host_tx_req_in,
  input wire logic        host_tx_ready_out,
  input wire logic        radio_tx_start_out,
  input wire logic        radio_repeat_out,
  input wire logic [7:0]  link_data_out,
  input wire logic        link_valid_out,
  input wire logic        link_ready_in
);
  logic [1:0]  mode_reg;
  logic [31:0] busy_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Shadow of the repeater mode, which the checker cannot read.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) mode_reg <= 2'h0;
    else if (reg_wr_in && reg_addr_in == 8'h00) mode_reg <= reg_wdata_in[1:0];
  end
  // Cycles with requests refused; a hung radio grows it.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) busy_reg <= 32'h0;
    else busy_reg <= host_tx_ready_out ? 32'h0 : busy_reg + 32'h1;
  end
  tx_start_a:
    assert property (host_tx_req_in && host_tx_ready_out |=> radio_tx_start_out) else $error("no tx start");
  tx_busy_a:
    assert property (radio_tx_start_out |-> !host_tx_ready_out) else $error("tx not busy");
  tx_window_a:
    assert property (busy_reg <= TX_WINDOW_CYCLES + 16) else $error("tx window overrun");
  rx_busy_a:
    assert property (rx_start_in && rx_ready_out |=> !rx_ready_out) else $error("rx not busy");
  rep_mode_a:
    assert property (radio_repeat_out |-> mode_reg == 2'h2) else $error("repeat outside mode");
  rep_time_a:
    assert property (radio_repeat_out |-> $past(rx_end_in, 2)) else $error("repeat mistimed");
  sync_first_a:
    assert property ($rose(link_valid_out) |-> link_data_out == 8'h55) else $error("bad sync");
  link_hold_a:
    assert property (link_valid_out && !link_ready_in |=> link_valid_out && $stable(link_data_out))
    else $error("byte dropped");
  cover property (radio_repeat_out);
  cover property ($rose(link_valid_out));
  cover property (radio_tx_start_out);
endmodule

bind rx_telegram_filter_forwarder filter_monitor #(.TX_WINDOW_CYCLES(TX_WINDOW_CYCLES)) mon (
  .clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .rx_start_in, .rx_end_in,
  .rx_ready_out, .host_tx_req_in, .host_tx_ready_out, .radio_tx_start_out, .radio_repeat_out,
  .link_data_out, .link_valid_out, .link_ready_in);

// ==== host_link_model.sv ====
// Host end of the byte link: collects packet bytes, stalling now and then.
// Assumes the sender holds each byte until it is taken.
module host_link_model (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Byte link.
  input  wire logic [7:0] link_data_in,
  input  wire logic       link_valid_in,
  output logic            link_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_reg;
  logic [7:0] got[$];
  // Ready drops one cycle in four, and power is never cut mid-send.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_reg      <= 2'h0;
      link_ready_out <= 1'b0;
    end else begin
      phase_reg      <= phase_reg + 2'h1;
      link_ready_out <= phase_reg != 2'h2;
      if (link_valid_in && link_ready_out) got.push_back(link_data_in);
    end
  end
endmodule

// ==== testbench.sv ====
// Self-checking bench: filter table rows, framing and host transmit.
// Assumes the forwarder's register map and a host model on the link.
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("ERROR %s expected %0h seen %0h", n, e, g); mismatches++; end end
module testbench;
  import telegram_filter_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic en; logic [7:0] ft; logic [31:0] fv; logic [7:0] act;
    logic [1:0] mode; logic [31:0] snd; logic [7:0] rssi, typ; logic [1:0] fr;} row_s;
  logic clk_in, reset_n_in, reg_wr_in, reg_rd_in, rx_start_in, rx_byte_valid_in;
  logic rx_byte_is_check_in, rx_end_in, host_tx_req_in, radio_tx_done_in, rep;
  logic rx_ready_out, host_tx_ready_out, radio_tx_start_out, radio_repeat_out, link_valid_out;
  logic link_ready_in;
  logic [7:0] reg_addr_in, rx_rssi_in, rx_subtel_in, rx_security_in, rx_byte_in, link_data_out;
  logic [31:0] reg_wdata_in, reg_rdata_out, rx_sender_id_in, rx_dest_id_in, d, dst;
  logic [7:0] body[$], exp_q[$];
  int mismatches, samples_checked;
  // Row: enable, type, value, action, mode, sender, strength, type, {forward, repeat}.
  row_s rows[11] = '{
    '{1'b1, 8'h00, 32'h12345678, 8'h00, 2'h0, 32'h12345678, 8'h30, 8'hA5, 2'h0},
    '{1'b1, 8'h00, 32'h12345678, 8'h80, 2'h0, 32'h12345678, 8'h30, 8'hA5, 2'h2},
    '{1'b1, 8'h01, 32'h000000A5, 8'h80, 2'h0, 32'h00000001, 8'h30, 8'hA5, 2'h2},
    '{1'b1, 8'h01, 32'h000000A5, 8'h00, 2'h2, 32'h00000001, 8'h30, 8'hA5, 2'h0},
    '{1'b1, 8'h02, 32'h00000046, 8'h00, 2'h0, 32'h00000001, 8'h46, 8'hA5, 2'h0},
    '{1'b1, 8'h02, 32'h00000046, 8'h00, 2'h0, 32'h00000001, 8'h45, 8'hA5, 2'h2},
    '{1'b1, 8'h00, 32'h12345678, 8'hC0, 2'h2, 32'h12345678, 8'h30, 8'hA5, 2'h3},
    '{1'b1, 8'h00, 32'h12345678, 8'hC0, 2'h0, 32'h12345678, 8'h30, 8'hA5, 2'h2},
    '{1'b1, 8'h01, 32'h000000A5, 8'h40, 2'h2, 32'h00000001, 8'h30, 8'hD5, 2'h3},
    '{1'b1, 8'h01, 32'h000000A5, 8'h40, 2'h2, 32'h00000001, 8'h30, 8'hA5, 2'h0},
    '{1'b0, 8'h00, 32'h12345678, 8'h00, 2'h2, 32'h12345678, 8'h30, 8'hA5, 2'h2}};
  rx_telegram_filter_forwarder #(.TX_WINDOW_CYCLES(50)) DUT (.clk_in, .reset_n_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_start_in,
    .rx_sender_id_in, .rx_dest_id_in, .rx_rssi_in, .rx_subtel_in, .rx_security_in,
    .rx_byte_valid_in, .rx_byte_in, .rx_byte_is_check_in, .rx_end_in, .rx_ready_out,
    .host_tx_req_in, .host_tx_ready_out, .radio_tx_start_out, .radio_repeat_out,
    .radio_tx_done_in, .link_data_out, .link_valid_out, .link_ready_in);
  host_link_model host (.clk_in, .reset_n_in, .link_data_in(link_data_out),
    .link_valid_in(link_valid_out), .link_ready_out(link_ready_in));
  // Bitwise checksum, independent of the design.
  function automatic logic [7:0] crc(input logic [7:0] c, b);
    logic [7:0] x;
    x = c ^ b;
    repeat (8) x = x[7] ? {x[6:0], 1'b0} ^ CRC_POLY : {x[6:0], 1'b0};
    return x;
  endfunction
  // Expected packet around body; its last ol bytes are optional.
  task automatic frame(input logic [7:0] pt, input int ol);
    logic [7:0] c;
    exp_q = '{8'h55, 8'h00, 8'(body.size() - ol), 8'(ol), pt};
    c = crc(crc(crc(crc(8'h00, 8'h00), exp_q[2]), exp_q[3]), pt);
    exp_q.push_back(c);
    c = 8'h00;
    foreach (body[i]) c = crc(c, body[i]);
    exp_q = {exp_q, body, c};
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, v};
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    {reg_rd_in, reg_addr_in} <= {1'b1, a};
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // One receive cycle: start, valid, check mark, end, then the byte.
  task automatic rxd(input logic [11:0] v);
    @(posedge clk_in);
    {rx_start_in, rx_byte_valid_in, rx_byte_is_check_in, rx_end_in, rx_byte_in} <= v;
  endtask
  // Waits for link and receiver to settle, then compares bytes.
  task automatic check_pkt();
    for (int n = 0; n < 300 && !(host.got.size() >= exp_q.size() && rx_ready_out); n++)
      @(posedge clk_in);
    repeat (3) @(posedge clk_in);
    #1 `CHK("length", exp_q.size(), host.got.size())
    foreach (exp_q[k]) if (k < host.got.size()) `CHK("byte", exp_q[k], host.got[k])
    host.got.delete();
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // The run needs about five hundred cycles; a hang ends here.
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    print_verdict();
  end
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, host_tx_req_in, radio_tx_done_in} = 5'h0;
    {reg_addr_in, reg_wdata_in, rx_sender_id_in, rx_dest_id_in, rx_rssi_in} = 80'h0;
    {rx_subtel_in, rx_security_in} = 16'h0300;
    rxd(12'h000);
    @(posedge clk_in);
    `CHK("rx ready", 1'b1, rx_ready_out)
    `CHK("link idle", 1'b0, link_valid_out)
    reset_n_in <= 1'b1;
    wr(8'h00, 32'h00000102);
    rd(8'h00);
    `CHK("ctrl", 32'h00000102, d)
    rd(8'h10);
    `CHK("unmapped", 32'h0, d)
    foreach (rows[i]) begin
      dst = i[0] ? 32'hFFFFFFFF : 32'h00ABCDEF;
      wr(8'h00, {30'h0, rows[i].mode});
      wr(8'h20, {15'h0, rows[i].en, rows[i].act, rows[i].ft});
      wr(8'h24, rows[i].fv);
      rxd(12'h800);
      {rx_sender_id_in, rx_dest_id_in, rx_rssi_in} <= {rows[i].snd, dst, rows[i].rssi};
      rx_security_in <= 8'(i % 5);
      rxd({4'h4, rows[i].typ});
      rxd(12'h401);
      rxd(12'h677);
      rxd(12'h100);
      rxd(12'h000);
      rep = 1'b0;
      repeat (4) @(posedge clk_in) #1 rep |= radio_repeat_out;
      body = '{rows[i].typ, 8'h01, 8'h00, dst[31:24], dst[23:16], dst[15:8], dst[7:0],
               rows[i].rssi, 8'(i % 5)};
      if (rows[i].fr[1]) frame(PTYPE_RADIO, 7);
      else exp_q = {};
      check_pkt();
      `CHK("repeat", rows[i].fr[0], rep)
    end
    // Host transmit, ended by done pulse, then by timeout.
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_in) host_tx_req_in <= 1'b1;
      @(posedge clk_in) host_tx_req_in <= 1'b0;
      #1 `CHK("tx start", 1'b1, radio_tx_start_out)
      `CHK("tx refused", 1'b0, host_tx_ready_out)
      body = '{8'h00};
      frame(PTYPE_RESPONSE, 0);
      check_pkt();
      if (t == 0) @(posedge clk_in) radio_tx_done_in <= 1'b1;
      @(posedge clk_in) radio_tx_done_in <= 1'b0;
      body = '{8'h08};
      frame(PTYPE_EVENT, 0);
      check_pkt();
      `CHK("tx free", 1'b1, host_tx_ready_out)
    end
    print_verdict();
  end
endmodule
